// [core/epos_top.sv]
// Purpose: register file and enable pin sequencer of a dual step-down regulator
// Assumes: serial port at standard, fast or fast-plus rate; pins are asynchronous
// Notes: converter and general output enables follow the trigger pin with delays
//
// Notes on behaviour
// - converter b codes 0x4c to 0x9d give 1 V upward in 5 mV steps.
// - converter b codes 0x9e to 0xff give 1.42 V upward in 20 mV steps.
// - converter a starts after its start-up delay from trigger rise; zero is immediate.
// - converter a stops after its shutdown delay from trigger fall.
// - converter b starts after its own start-up delay, independent of converter a.
// - converter b stops after its own shutdown delay from trigger fall.
// - output one rises after its start-up delay from trigger rise.
// - output one falls after its shutdown delay from trigger fall.
// - output two rises after its start-up delay from trigger rise.
// - output two falls after its shutdown delay from trigger fall.
// - start-up step bit selects 0.5 ms or 1 ms per start-up count.
// - shutdown step bit selects 0.5 ms or 1 ms per shutdown count.
// - output one is its level bit, or level AND trigger when gated.
// - output two is its level bit, or level AND trigger when gated.
// - output one level bit drives low for 0, high for 1.
// - output two level applies only while shared pin is a general output.
// - output one drive bit selects push-pull for 0, open-drain for 1.
// - output two drive bit selects push-pull or open-drain as general output.
// - shared pin function bit: 0 general output two, 1 clock input.
// - thermal threshold bit: 0 selects 125 C, 1 selects 137 C.
// - spread-spectrum bit: 0 off, 1 on.
// - converter follows enable bit, or enable AND trigger when gated.
`timescale 1ns/1ns
`default_nettype none
module epos_top #(
  parameter logic [6:0] DEV_ADDR = 7'h60, // arbitrary value
  parameter int HALF_MS_CYCLES = epos_pkg::TICK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N,
  input wire logic EN_PIN,
  output logic CONV_A_EN,
  output logic CONV_B_EN,
  output logic [11:0] CONV_B_MV,
  output logic OUT_ONE_O,
  output logic OUT_ONE_OE_N,
  output logic OUT_TWO_O,
  output logic OUT_TWO_OE_N,
  output logic SHARED_PIN_IS_CLOCK,
  output logic SHARED_PIN_PULLDOWN,
  output logic TRIGGER_PIN_PULLDOWN,
  output logic THERMAL_WARN_HIGH,
  output logic SPREAD_SPECTRUM_ON
);
  localparam int TW = (HALF_MS_CYCLES > 1) ? $clog2(HALF_MS_CYCLES) : 1;

  // refuse a tick too short for the prescaler
  if (HALF_MS_CYCLES < 2) begin : g_bad_tick
    $error("HALF_MS_CYCLES must be at least 2");
  end

  // pin synchronisers: index 0 scl, 1 sda, 2 trigger pin
  logic [2:0] pin_q1_r;
  logic [2:0] pin_q2_r;
  logic [2:0] pin_q3_r;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_q1_r <= 3'h3; // trigger idles low, serial lines idle high
      pin_q2_r <= 3'h3;
      pin_q3_r <= 3'h3;
    end else begin
      pin_q1_r <= {EN_PIN, SDA_I, SCL};
      pin_q2_r <= pin_q1_r;
      pin_q3_r <= pin_q2_r;
    end
  end

  logic scl_s, sda_s, en_s;
  logic scl_rise, scl_fall, ser_start, ser_stop, en_edge;
  assign scl_s = pin_q2_r[0];
  assign sda_s = pin_q2_r[1];
  assign en_s = pin_q2_r[2];
  assign scl_rise = scl_s & ~pin_q3_r[0];
  assign scl_fall = ~scl_s & pin_q3_r[0];
  assign ser_start = scl_s & pin_q3_r[0] & ~sda_s & pin_q3_r[1];
  assign ser_stop = scl_s & pin_q3_r[0] & sda_s & ~pin_q3_r[1];
  assign en_edge = en_s ^ pin_q3_r[2];

  // registers
  logic [1:0] ctrl_a_r, ctrl_b_r;
  logic [7:0] vcode_r, outctl_r, cfg_r;
  logic [7:0] dly_r [epos_pkg::NUM_CH];
  logic [7:0] ptr_r, shift_r, rd_data;
  logic [3:0] bits_r;
  logic rw_r, sda_oe_n_r, wr_stb;
  epos_pkg::epos_ser_e state_r;

  // serial port: byte framing, acknowledge and open-drain data drive
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state_r <= epos_pkg::ST_IDLE;
      bits_r <= 4'h0;
      shift_r <= epos_pkg::RST_BYTE;
      ptr_r <= epos_pkg::RST_BYTE;
      rw_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end else if (ser_start) begin
      state_r <= epos_pkg::ST_ADDR;
      bits_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end else if (ser_stop) begin
      state_r <= epos_pkg::ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end else begin
      unique case (state_r)
        epos_pkg::ST_IDLE: begin
          sda_oe_n_r <= 1'b1;
        end
        epos_pkg::ST_ADDR, epos_pkg::ST_REG, epos_pkg::ST_WDATA: begin
          if (scl_rise && bits_r != epos_pkg::BYTE_BITS) begin
            shift_r <= {shift_r[6:0], sda_s};
            bits_r <= bits_r + 4'h1;
          end else if (scl_fall && bits_r == epos_pkg::BYTE_BITS) begin
            bits_r <= 4'h0;
            if (state_r == epos_pkg::ST_ADDR) begin
              if (shift_r[7:1] == DEV_ADDR) begin
                rw_r <= shift_r[0];
                sda_oe_n_r <= 1'b0;
                state_r <= epos_pkg::ST_ADDR_ACK;
              end else begin
                state_r <= epos_pkg::ST_IDLE; // other device addressed
              end
            end else if (state_r == epos_pkg::ST_REG) begin
              ptr_r <= shift_r;
              sda_oe_n_r <= 1'b0;
              state_r <= epos_pkg::ST_REG_ACK;
            end else begin
              sda_oe_n_r <= 1'b0;
              state_r <= epos_pkg::ST_WDATA_ACK;
            end
          end
        end
        epos_pkg::ST_ADDR_ACK: begin
          if (scl_fall && rw_r) begin
            shift_r <= rd_data;
            sda_oe_n_r <= rd_data[7];
            bits_r <= 4'h1;
            state_r <= epos_pkg::ST_RDATA;
          end else if (scl_fall) begin
            sda_oe_n_r <= 1'b1;
            state_r <= epos_pkg::ST_REG;
          end
        end
        epos_pkg::ST_REG_ACK: begin
          if (scl_fall) begin
            sda_oe_n_r <= 1'b1;
            state_r <= epos_pkg::ST_WDATA;
          end
        end
        epos_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_n_r <= 1'b1;
            ptr_r <= ptr_r + 8'h01; // auto-increment for bursts
            state_r <= epos_pkg::ST_WDATA;
          end
        end
        epos_pkg::ST_RDATA: begin
          if (scl_fall && bits_r == epos_pkg::BYTE_BITS) begin
            sda_oe_n_r <= 1'b1; // release for the master acknowledge
            bits_r <= 4'h0;
            ptr_r <= ptr_r + 8'h01;
            state_r <= epos_pkg::ST_RDATA_ACK;
          end else if (scl_fall) begin
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe_n_r <= shift_r[6];
            bits_r <= bits_r + 4'h1;
          end
        end
        epos_pkg::ST_RDATA_ACK: begin
          if (scl_rise && sda_s) begin
            state_r <= epos_pkg::ST_IDLE; // not acknowledged: stop sending
          end else if (scl_rise) begin
            bits_r <= 4'h1;
          end else if (scl_fall && bits_r == 4'h1) begin
            shift_r <= rd_data;
            sda_oe_n_r <= rd_data[7];
            state_r <= epos_pkg::ST_RDATA;
          end
        end
      endcase
    end
  end

  assign wr_stb = (state_r == epos_pkg::ST_WDATA) && scl_fall && !ser_start && !ser_stop
    && bits_r == epos_pkg::BYTE_BITS;

  // register writes
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_a_r <= 2'h0;
      ctrl_b_r <= 2'h0;
      vcode_r <= epos_pkg::RST_VCODE;
      outctl_r <= epos_pkg::RST_BYTE;
      cfg_r <= epos_pkg::RST_BYTE;
      for (int i = 0; i < epos_pkg::NUM_CH; i++) begin
        dly_r[i] <= epos_pkg::RST_BYTE;
      end
    end else if (wr_stb) begin
      unique case (ptr_r)
        epos_pkg::REG_CONV_A_CTRL: ctrl_a_r <= shift_r[1:0];
        epos_pkg::REG_CONV_B_CTRL: ctrl_b_r <= shift_r[1:0];
        epos_pkg::REG_CONV_B_VOLT: vcode_r <= shift_r;
        epos_pkg::REG_CONV_A_DLY: dly_r[epos_pkg::CH_CONV_A] <= shift_r;
        epos_pkg::REG_CONV_B_DLY: dly_r[epos_pkg::CH_CONV_B] <= shift_r;
        epos_pkg::REG_OUT_ONE_DLY: dly_r[epos_pkg::CH_OUT_ONE] <= shift_r;
        epos_pkg::REG_OUT_TWO_DLY: dly_r[epos_pkg::CH_OUT_TWO] <= shift_r;
        epos_pkg::REG_OUT_CTRL: outctl_r <= shift_r & epos_pkg::OUT_CTRL_MASK;
        epos_pkg::REG_DEV_CFG: cfg_r <= shift_r;
        default: ; // unmapped offsets ignore writes
      endcase
    end
  end

  // register read mux; unmapped offsets read zero
  always_comb begin
    unique case (ptr_r)
      epos_pkg::REG_CONV_A_CTRL: rd_data = {6'h00, ctrl_a_r};
      epos_pkg::REG_CONV_B_CTRL: rd_data = {6'h00, ctrl_b_r};
      epos_pkg::REG_CONV_B_VOLT: rd_data = vcode_r;
      epos_pkg::REG_CONV_A_DLY: rd_data = dly_r[epos_pkg::CH_CONV_A];
      epos_pkg::REG_CONV_B_DLY: rd_data = dly_r[epos_pkg::CH_CONV_B];
      epos_pkg::REG_OUT_ONE_DLY: rd_data = dly_r[epos_pkg::CH_OUT_ONE];
      epos_pkg::REG_OUT_TWO_DLY: rd_data = dly_r[epos_pkg::CH_OUT_TWO];
      epos_pkg::REG_OUT_CTRL: rd_data = outctl_r;
      epos_pkg::REG_DEV_CFG: rd_data = cfg_r;
      default: rd_data = epos_pkg::RST_BYTE;
    endcase
  end

  // free-running half millisecond tick
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TW'(HALF_MS_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
      tick_r <= 1'b0;
    end
  end

  // one delay channel per sequenced output
  logic [epos_pkg::NUM_CH-1:0] seq_r, pend_r;
  for (genvar g = 0; g < epos_pkg::NUM_CH; g++) begin : g_ch
    logic [3:0] fld;
    logic [4:0] ticks;
    logic [4:0] cnt_r;
    assign fld = en_s ? dly_r[g][epos_pkg::ON_LSB +: epos_pkg::DLY_W]
                      : dly_r[g][epos_pkg::OFF_LSB +: epos_pkg::DLY_W];
    // step doubles when the edge's step bit is set
    assign ticks = (en_s ? cfg_r[epos_pkg::CFG_ON_SEL] : cfg_r[epos_pkg::CFG_OFF_SEL])
      ? {fld, 1'b0} : {1'b0, fld};
    always_ff @(posedge CLOCK) begin
      if (RST) begin
        seq_r[g] <= 1'b0;
        pend_r[g] <= 1'b0;
        cnt_r <= 5'h00;
      end else if (en_edge && fld == 4'h0) begin
        seq_r[g] <= en_s;
        pend_r[g] <= 1'b0;
      end else if (en_edge) begin
        pend_r[g] <= 1'b1;
        cnt_r <= ticks + 5'h01; // partial first tick not counted
      end else if (pend_r[g] && tick_r && cnt_r == 5'h01) begin
        seq_r[g] <= en_s;
        pend_r[g] <= 1'b0;
        cnt_r <= 5'h00;
      end else if (pend_r[g] && tick_r) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end

  // converter b millivolt target from its code
  logic [11:0] mv_nxt;
  always_comb begin
    if (vcode_r >= epos_pkg::VCODE_HI_MIN) begin
      mv_nxt = epos_pkg::MV_HI_BASE + 12'({4'h0, vcode_r - epos_pkg::VCODE_HI_MIN}
        * epos_pkg::MV_HI_STEP);
    end else if (vcode_r >= epos_pkg::VCODE_LO_MIN) begin
      mv_nxt = epos_pkg::MV_LO_BASE + 12'({4'h0, vcode_r - epos_pkg::VCODE_LO_MIN}
        * epos_pkg::MV_LO_STEP);
    end else begin
      mv_nxt = epos_pkg::MV_LO_BASE; // reserved codes clamp to the floor
    end
  end

  // gated level of each output
  logic a_on, b_on, one_on, two_on, two_gpo;
  assign a_on = ctrl_a_r[epos_pkg::CTRL_EN_BIT]
    & (~ctrl_a_r[epos_pkg::CTRL_GATE_BIT] | seq_r[epos_pkg::CH_CONV_A]);
  assign b_on = ctrl_b_r[epos_pkg::CTRL_EN_BIT]
    & (~ctrl_b_r[epos_pkg::CTRL_GATE_BIT] | seq_r[epos_pkg::CH_CONV_B]);
  assign one_on = outctl_r[epos_pkg::OUT_ONE_LEVEL]
    & (~outctl_r[epos_pkg::OUT_ONE_GATE] | seq_r[epos_pkg::CH_OUT_ONE]);
  assign two_on = outctl_r[epos_pkg::OUT_TWO_LEVEL]
    & (~outctl_r[epos_pkg::OUT_TWO_GATE] | seq_r[epos_pkg::CH_OUT_TWO]);
  assign two_gpo = ~cfg_r[epos_pkg::CFG_SHARED_FN];

  // registered outputs; open-drain drives low only, releases for high
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CONV_A_EN <= 1'b0;
      CONV_B_EN <= 1'b0;
      CONV_B_MV <= epos_pkg::MV_LO_BASE;
      OUT_ONE_O <= 1'b0;
      OUT_ONE_OE_N <= 1'b1;
      OUT_TWO_O <= 1'b0;
      OUT_TWO_OE_N <= 1'b1;
      SHARED_PIN_IS_CLOCK <= 1'b0;
      SHARED_PIN_PULLDOWN <= 1'b0;
      TRIGGER_PIN_PULLDOWN <= 1'b0;
      THERMAL_WARN_HIGH <= 1'b0;
      SPREAD_SPECTRUM_ON <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE_N <= 1'b1;
    end else begin
      CONV_A_EN <= a_on;
      CONV_B_EN <= b_on;
      CONV_B_MV <= mv_nxt;
      OUT_ONE_O <= outctl_r[epos_pkg::OUT_ONE_DRIVE] ? 1'b0 : one_on;
      OUT_ONE_OE_N <= outctl_r[epos_pkg::OUT_ONE_DRIVE] & one_on;
      OUT_TWO_O <= two_gpo & ~outctl_r[epos_pkg::OUT_TWO_DRIVE] & two_on;
      OUT_TWO_OE_N <= ~two_gpo | (outctl_r[epos_pkg::OUT_TWO_DRIVE] & two_on);
      SHARED_PIN_IS_CLOCK <= ~two_gpo;
      SHARED_PIN_PULLDOWN <= cfg_r[epos_pkg::CFG_SHARED_PD];
      TRIGGER_PIN_PULLDOWN <= cfg_r[epos_pkg::CFG_TRIG_PD];
      THERMAL_WARN_HIGH <= cfg_r[epos_pkg::CFG_THERM];
      SPREAD_SPECTRUM_ON <= cfg_r[epos_pkg::CFG_SPREAD];
      SDA_O <= 1'b0;
      SDA_OE_N <= sda_oe_n_r;
    end
  end

  // checks
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);

  seq_zero_a: assert property ($rose(en_s) && dly_r[0][3:0] == 4'h0 |=> seq_r[0])
    else $error("zero start-up delay did not act at once");
  conv_a_on_a: assert property ($rose(en_s) && dly_r[0][3:0] == 4'h0 && ctrl_a_r == 2'h3
    ##1 ctrl_a_r == 2'h3 |=> CONV_A_EN)
    else $error("gated converter a did not start");
  cancel_rise_a: assert property (en_edge && !en_s && pend_r[1] && !seq_r[1]
    |=> !seq_r[1] && pend_r[1] == ($past(dly_r[1][7:4]) != 4'h0))
    else $error("pending start survived a falling edge");
  off_hold_a: assert property ($fell(en_s) && dly_r[1][7:4] != 4'h0 && seq_r[1]
    |=> seq_r[1] && pend_r[1])
    else $error("converter b stopped before its shutdown delay");
  out_one_pp_a: assert property (outctl_r[2:0] == 3'h1 |=> OUT_ONE_O && !OUT_ONE_OE_N)
    else $error("output one push-pull high not driven");
  out_one_od_a: assert property (outctl_r[2] |=> !OUT_ONE_O)
    else $error("open-drain output one drove high");
  shared_clk_a: assert property (cfg_r[4] |=> OUT_TWO_OE_N && SHARED_PIN_IS_CLOCK)
    else $error("shared pin driven while a clock input");
  vcode_lo_a: assert property (vcode_r == 8'h4c |=> CONV_B_MV == 12'h3e8)
    else $error("code 0x4c does not give 1000 mV");
  vcode_hi_a: assert property (vcode_r == 8'hff |=> CONV_B_MV == 12'hd20)
    else $error("code 0xff does not give 3360 mV");
  tick_step_a: assert property (pend_r[2] && !tick_r && !en_edge
    |=> $stable(g_ch[2].cnt_r))
    else $error("delay counter moved without a tick");

  write_seen_c: cover property (wr_stb && ptr_r == epos_pkg::REG_DEV_CFG);
  read_seen_c: cover property (state_r == epos_pkg::ST_RDATA_ACK);
  delayed_on_c: cover property (pend_r[0] && tick_r && g_ch[0].cnt_r == 5'h01 && en_s);
  cancel_c: cover property (en_edge && pend_r[3]);
endmodule // epos_top
`default_nettype wire

// [core/epos_pkg.sv]
// Purpose: constants shared by the enable pin output sequencer
// Assumes: 50 MHz core clock, byte-wide registers behind a two-wire serial port
// Notes: register offsets, field positions, reset values and timing counts
package epos_pkg;
  // register offsets
  localparam logic [7:0] REG_CONV_A_CTRL = 8'h02;
  localparam logic [7:0] REG_CONV_B_CTRL = 8'h04;
  localparam logic [7:0] REG_CONV_B_VOLT = 8'h07;
  localparam logic [7:0] REG_CONV_A_DLY = 8'h0c;
  localparam logic [7:0] REG_CONV_B_DLY = 8'h0d;
  localparam logic [7:0] REG_OUT_ONE_DLY = 8'h10;
  localparam logic [7:0] REG_OUT_TWO_DLY = 8'h11;
  localparam logic [7:0] REG_OUT_CTRL = 8'h12;
  localparam logic [7:0] REG_DEV_CFG = 8'h13;
  // converter control fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_GATE_BIT = 1;
  // delay register fields
  localparam int ON_LSB = 0;
  localparam int OFF_LSB = 4;
  localparam int DLY_W = 4;
  // general outputs control fields; bits 7 and 3 read as zero
  localparam int OUT_ONE_LEVEL = 0;
  localparam int OUT_ONE_GATE = 1;
  localparam int OUT_ONE_DRIVE = 2;
  localparam int OUT_TWO_LEVEL = 4;
  localparam int OUT_TWO_GATE = 5;
  localparam int OUT_TWO_DRIVE = 6;
  localparam logic [7:0] OUT_CTRL_MASK = 8'h77;
  // device configuration fields
  localparam int CFG_SPREAD = 0;
  localparam int CFG_THERM = 1;
  localparam int CFG_TRIG_PD = 2;
  localparam int CFG_SHARED_PD = 3;
  localparam int CFG_SHARED_FN = 4;
  localparam int CFG_OFF_SEL = 5;
  localparam int CFG_ON_SEL = 6;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_VCODE = 8'h4c;
  // voltage code map of converter b, millivolts
  localparam logic [7:0] VCODE_LO_MIN = 8'h4c;
  localparam logic [7:0] VCODE_HI_MIN = 8'h9e;
  localparam logic [11:0] MV_LO_BASE = 12'h3e8;
  localparam logic [11:0] MV_LO_STEP = 12'h005;
  localparam logic [11:0] MV_HI_BASE = 12'h58c;
  localparam logic [11:0] MV_HI_STEP = 12'h014;
  // sequencing timing: half millisecond tick, long step is two ticks
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 500000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_CH = 4;
  localparam int CH_CONV_A = 0;
  localparam int CH_CONV_B = 1;
  localparam int CH_OUT_ONE = 2;
  localparam int CH_OUT_TWO = 3;
  // serial port
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA,
    ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK} epos_ser_e;
endpackage

// [tb/epos_host.sv]
// Purpose: host model for the serial port and the trigger pin
// Assumes: five core clocks per serial phase, data line pulled up outside
// Notes: RD_DONE pulses for one cycle with each byte read
`timescale 1ns/1ns
`default_nettype none
module epos_host (
  input wire logic CLOCK,
  input wire logic SDA,
  output logic SCL,
  output logic SDA_LOW,
  output logic EN_PIN,
  output logic RD_DONE,
  output logic [7:0] RD_BYTE
);
  // idle bus, trigger low
  initial begin
    SCL = 1'b1;
    SDA_LOW = 1'b0;
    EN_PIN = 1'b0;
    RD_DONE = 1'b0;
    RD_BYTE = 8'h00;
  end
  // drive both lines, then hold them one phase
  task automatic pin(input logic c, input logic l);
    SCL <= c;
    SDA_LOW <= l;
    repeat (5) @(posedge CLOCK);
  endtask
  // start or repeated start; leaves clock high, data low
  task automatic start();
    pin(1'b0, SDA_LOW);
    pin(1'b0, 1'b0);
    pin(1'b1, 1'b0);
    pin(1'b1, 1'b1);
  endtask
  task automatic stop();
    pin(1'b0, SDA_LOW);
    pin(1'b0, 1'b1);
    pin(1'b1, 1'b1);
    pin(1'b1, 1'b0);
  endtask
  // one bit slot: data only moves while the clock is low
  task automatic slot(input logic l, output logic s);
    pin(1'b0, SDA_LOW);
    pin(1'b0, l);
    pin(1'b1, l);
    s = SDA;
  endtask
  task automatic put(input logic [7:0] b, output logic ok);
    logic s;
    for (int i = 7; i >= 0; i--) slot(b[i] == 1'b0, s);
    slot(1'b0, s);
    ok = ~s;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d,
    output logic ok);
    logic k1, k2, k3;
    start();
    put({a, 1'b0}, k1);
    put(o, k2);
    put(d, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  // single byte read ended by a not-acknowledge
  task automatic rd(input logic [6:0] a, input logic [7:0] o, output logic ok);
    logic k1, k2, k3, s;
    logic [7:0] b;
    start();
    put({a, 1'b0}, k1);
    put(o, k2);
    start();
    put({a, 1'b1}, k3);
    for (int i = 7; i >= 0; i--) slot(1'b0, b[i]);
    slot(1'b0, s);
    stop();
    ok = k1 & k2 & k3;
    RD_BYTE <= b;
    RD_DONE <= 1'b1;
    @(posedge CLOCK);
    RD_DONE <= 1'b0;
  endtask
  task automatic set_en(input logic v);
    EN_PIN <= v;
  endtask
endmodule // epos_host
`default_nettype wire

// [tb/test_enable_pin_output_sequencer.sv]
// Purpose: self-checking bench for the enable pin output sequencer
// Assumes: tick shortened to 50 clocks, host model on the serial port
// Notes: a monitor matches output changes and read bytes to queued notes
`timescale 1ns/1ns
`default_nettype none
module test_enable_pin_output_sequencer;
  localparam int TK = 50;
  localparam logic [6:0] DEV = 7'h2a; // arbitrary value
  localparam logic [7:0] OFFS [10] = '{8'h02, 8'h04, 8'h07, 8'h0c, 8'h0d, 8'h10, 8'h11,
    8'h12, 8'h13, 8'h30};
  localparam logic [7:0] DOFF [4] = '{8'h0c, 8'h0d, 8'h10, 8'h11};
  localparam logic [7:0] DFIX [4] = '{8'hf0, 8'h0f, 8'h21, 8'h73};
  localparam logic [7:0] VC [5] = '{8'h9d, 8'h9e, 8'hff, 8'h4c, 8'h4d};
  typedef struct {logic rd; logic [22:0] v; longint lo; longint hi;} epos_note_s;
  logic clock, rst, scl, sda, sda_low, en_pin, rd_done, sda_o, sda_oe_n;
  logic a_en, b_en, o1, o1n, o2, o2n, sclk, spd, tpd, thw, ssp;
  logic [11:0] mv;
  logic [7:0] rd_byte;
  logic [22:0] vec, prev, last;
  logic [7:0] regs [256];
  logic [3:0] seq = 4'h0;
  epos_note_s q[$];
  int n_mismatch = 0;
  int checks_done = 0;
  longint cyc = 0;
  bit armed = 1'b0;
  // data line with pull-up; watched output vector
  assign sda = ~sda_low & (sda_oe_n | sda_o);
  assign vec = {a_en, b_en, mv, o1, o1n, o2, o2n, sclk, spd, tpd, thw, ssp};
  epos_top #(.DEV_ADDR(DEV), .HALF_MS_CYCLES(TK)) u_dut (.CLOCK(clock), .RST(rst), .SCL(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .EN_PIN(en_pin), .CONV_A_EN(a_en),
    .CONV_B_EN(b_en), .CONV_B_MV(mv), .OUT_ONE_O(o1), .OUT_ONE_OE_N(o1n), .OUT_TWO_O(o2),
    .OUT_TWO_OE_N(o2n), .SHARED_PIN_IS_CLOCK(sclk), .SHARED_PIN_PULLDOWN(spd),
    .TRIGGER_PIN_PULLDOWN(tpd), .THERMAL_WARN_HIGH(thw), .SPREAD_SPECTRUM_ON(ssp));
  epos_host u_host (.CLOCK(clock), .SDA(sda), .SCL(scl), .SDA_LOW(sda_low), .EN_PIN(en_pin),
    .RD_DONE(rd_done), .RD_BYTE(rd_byte));
  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input bit c, input string s);
    checks_done++;
    if (!c) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, s);
    end
  endtask
  // writable bits of each offset; unmapped offsets hold nothing
  function automatic logic [7:0] msk(input logic [7:0] o);
    case (o)
      8'h02, 8'h04: return 8'h03;
      8'h12: return 8'h77;
      8'h07, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h13: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  // expected output vector from the register model and sequencer state
  function automatic logic [22:0] ev();
    logic [7:0] c, oc, vc;
    logic a, b, p, r;
    logic [11:0] m;
    oc = regs[8'h12];
    c = regs[8'h13];
    vc = regs[8'h07];
    a = regs[8'h02][0] & (~regs[8'h02][1] | seq[0]);
    b = regs[8'h04][0] & (~regs[8'h04][1] | seq[1]);
    p = oc[0] & (~oc[1] | seq[2]);
    r = oc[4] & (~oc[5] | seq[3]);
    m = (vc < 8'h9e) ? 12'h3e8 + 12'(5 * (vc - 8'h4c)) : 12'h58c + 12'(20 * (vc - 8'h9e));
    return {a, b, m, ~oc[2] & p, oc[2] & p, ~c[4] & ~oc[6] & r, c[4] | (oc[6] & r), c[4:0]};
  endfunction
  // delay in ticks of one channel for a given trigger edge
  function automatic int dly(input int ch, input logic v);
    logic [7:0] r, c;
    r = regs[DOFF[ch]];
    c = regs[8'h13];
    return (v ? int'(r[3:0]) : int'(r[7:4])) * ((v ? c[6] : c[5]) ? 2 : 1);
  endfunction
  task automatic note(input longint lo, input longint hi);
    logic [22:0] v;
    v = ev();
    if (v !== last) begin
      q.push_back('{1'b0, v, lo, hi});
      last = v;
    end
  endtask
  task automatic wr(input logic [7:0] o, input logic [7:0] d);
    logic ok;
    regs[o] = d & msk(o);
    note(cyc, cyc + 3000);
    u_host.wr(DEV, o, d, ok);
    chk(ok === 1'b1, "write not acknowledged");
  endtask
  task automatic rd(input logic [7:0] o);
    logic ok;
    q.push_back('{1'b1, {15'h0000, regs[o]}, cyc, cyc + 3000});
    u_host.rd(DEV, o, ok);
    chk(ok === 1'b1, "read not acknowledged");
  endtask
  // trigger edge: note each channel's change in delay order
  task automatic trig(input logic v);
    longint t;
    t = cyc;
    u_host.set_en(v);
    for (int k = 0; k < 31; k++) begin
      for (int ch = 0; ch < 4; ch++) if (dly(ch, v) == k) seq[ch] = v;
      note(k == 0 ? t : t + k * TK, k == 0 ? t + 10 : t + (k + 1) * TK + 10);
    end
    repeat (32 * TK) @(posedge clock);
  endtask
  // short pulse that must cancel the pending change
  task automatic pulse(input logic v);
    u_host.set_en(v);
    repeat (3 * TK) @(posedge clock);
    u_host.set_en(~v);
    repeat (20 * TK) @(posedge clock);
  endtask
  task automatic take(input logic k, input logic [22:0] v);
    epos_note_s n;
    if (q.size() > 0) begin
      n = q.pop_front();
    end else begin
      n = '{~k, 23'h0, 64'h0, 64'h0}; // nothing expected: forces a mismatch
    end
    chk(n.rd === k && n.v === v && cyc >= n.lo && cyc <= n.hi,
      $sformatf("result %h against note %h", v, n.v));
  endtask
  // monitor: every output change or read byte consumes the oldest note
  always @(posedge clock) begin
    cyc++;
    if (armed && (vec !== prev)) take(1'b0, vec);
    if (rd_done === 1'b1) take(1'b1, {15'h0000, rd_byte});
    prev = vec;
  end
  // watchdog
  initial begin
    repeat (90000) @(posedge clock);
    chk(1'b0, "run timed out");
    report_and_stop();
  end
  // main sequence
  initial begin
    logic ok;
    rst = 1'b1;
    void'($urandom(32'h1a0ab576));
    foreach (regs[i]) regs[i] = 8'h00;
    regs[8'h07] = 8'h4c;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (5) @(posedge clock);
    last = ev();
    chk(vec === last, "outputs after reset");
    prev = vec;
    armed = 1'b1;
    foreach (OFFS[i]) rd(OFFS[i]);
    u_host.wr(DEV ^ 7'h01, 8'h12, 8'h11, ok);
    chk(ok === 1'b0, "foreign address acknowledged");
    for (int i = 0; i < 8; i++) wr(8'h13, 8'h01 << i);
    foreach (VC[i]) wr(8'h07, VC[i]);
    repeat (4) wr(8'h07, 8'($urandom_range(32'hff, 32'h4c)));
    repeat (6) begin
      wr(8'h13, {3'b000, 1'($urandom), 4'h0});
      wr(8'h12, 8'($urandom));
      rd(8'h12);
    end
    wr(8'h02, 8'hff);
    wr(8'h04, 8'h01);
    rd(8'h02);
    wr(8'h04, 8'h03);
    for (int p = 0; p < 3; p++) begin
      wr(8'h13, 8'(p * 32));
      wr(8'h12, p == 2 ? 8'h77 : 8'h33);
      foreach (DOFF[i]) wr(DOFF[i], p == 0 ? DFIX[i] : 8'($urandom));
      trig(1'b1);
      trig(1'b0);
      foreach (DOFF[i]) rd(DOFF[i]);
    end
    foreach (DOFF[i]) wr(DOFF[i], 8'h88);
    wr(8'h13, 8'h00);
    pulse(1'b1);
    trig(1'b1);
    pulse(1'b0);
    wr(8'h30, 8'h5a);
    rd(8'h30);
    repeat (20) @(posedge clock);
    chk(q.size() == 0, "results missing");
    report_and_stop();
  end
endmodule // test_enable_pin_output_sequencer
`default_nettype wire
